// *** core/pressure_readout_display_ctrl.sv ***
// pressure readout controller: offset capture, span scaling and static lcd drive
// Summary of operation
// - sensor read on converter channel five
// - converter results are unsigned 0 to 255
// - zero offset captured at every power-up
// - pressure shown 0 to 15 psi, tenths
// - data and backplane invert together near 30 Hz
// - show CAL about 5 s, then pressure
// - jumpers trim span up or down 1.5%
// - four digits, three used plus decimal point
// - all timing derived from the one clock
// - each sample sums one hundred conversions
// - 30 ms timer event triggers each alternation
`timescale 1ns/1ps
`include "pressure_defs.svh"

module pressure_readout_display_ctrl
  import pressure_pkg::*;
#(
  parameter int unsigned CAL_CYCLES   = `PRD_CAL_CYCLES,
  parameter int unsigned FRAME_CYCLES = `PRD_FRAME_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic span_raise_jumper,
  input  wire logic span_lower_jumper,
  output conv_req_s conv_req,
  input  conv_rsp_s conv_rsp,
  output lcd_drive_s lcd
);

  // --------------------------------------------------------------------------
  // jumper synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] jmp_s1_q;
  logic [1:0] jmp_s2_q;
  logic [1:0] jmp_s3_q;
  logic [1:0] jmp_q;

  // the first stage feeds only the second; a change is taken once stages 2 and 3 agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      jmp_s1_q <= 2'b00;
      jmp_s2_q <= 2'b00;
      jmp_s3_q <= 2'b00;
      jmp_q    <= 2'b00;
    end else begin
      jmp_s1_q <= {span_lower_jumper, span_raise_jumper};
      jmp_s2_q <= jmp_s1_q;
      jmp_s3_q <= jmp_s2_q;
      for (int i = 0; i < 2; i++) begin
        if (jmp_s2_q[i] == jmp_s3_q[i]) begin
          jmp_q[i] <= jmp_s3_q[i];
        end
      end
    end
  end

  // both or neither installed keeps the nominal span
  wire logic [8:0] span = (jmp_q == 2'b01) ? `PRD_SPAN_RAISE :
                          (jmp_q == 2'b10) ? `PRD_SPAN_LOWER :
                                             `PRD_SPAN_NOM;

  // --------------------------------------------------------------------------
  // timers, both counted on core_clk
  // --------------------------------------------------------------------------
  logic [31:0] frame_cnt_q;
  logic [31:0] cal_cnt_q;
  wire logic   frame_tick = (frame_cnt_q == FRAME_CYCLES - 1);
  wire logic   cal_done   = (cal_cnt_q == CAL_CYCLES - 1);

  // free running frame timer; warm-up timer runs only in the warm-up state
  ctrl_state_e state_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_cnt_q <= 32'h0000_0000;
      cal_cnt_q   <= 32'h0000_0000;
    end else begin
      frame_cnt_q <= frame_tick ? 32'h0000_0000 : frame_cnt_q + 32'h0000_0001;
      if (state_q == ST_WARMUP) begin
        cal_cnt_q <= cal_cnt_q + 32'h0000_0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // conversion accumulation
  // --------------------------------------------------------------------------
  logic        busy_q;
  logic [6:0]  conv_cnt_q;
  logic [14:0] sum_q;
  logic [14:0] offset_q;
  logic [7:0]  tenths_q;

  // one conversion in flight at a time keeps the channel handshake trivial
  wire logic acq_active = (state_q == ST_ZERO) || (state_q == ST_MEASURE);
  wire logic sum_last   = conv_rsp.done && busy_q && (conv_cnt_q == `PRD_SUM_LAST);
  assign conv_req.start   = acq_active && !busy_q;
  assign conv_req.channel = `PRD_ADC_CHANNEL;

  // the 8-bit result is unsigned, so zero-extend into the sum
  wire logic [14:0] sum_d = sum_q + {7'h00, conv_rsp.data};

  // --------------------------------------------------------------------------
  // pressure arithmetic
  // --------------------------------------------------------------------------
  wire logic [14:0] diff    = (sum_q > offset_q) ? (sum_q - offset_q) : 15'h0000;
  wire logic [23:0] product = {9'h000, diff} * {15'h0000, span};
  wire logic [7:0]  scaled  = product[`PRD_SPAN_SHIFT +: 8];
  // a full 100-read sum times the largest span stays below 2**24, so the top byte holds the whole result
  wire logic        over    = (scaled > `PRD_MAX_TENTHS);
  wire logic [7:0]  tenths_d = over ? `PRD_MAX_TENTHS : scaled;

  // --------------------------------------------------------------------------
  // control state machine
  // --------------------------------------------------------------------------
  // reset is held by the external undervoltage detector until supply is good
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_WARMUP;
      busy_q     <= 1'b0;
      conv_cnt_q <= 7'h00;
      sum_q      <= 15'h0000;
      offset_q   <= 15'h0000;
      tenths_q   <= 8'h00;
    end else begin
      if (conv_req.start) begin
        busy_q <= 1'b1;
      end else if (conv_rsp.done) begin
        busy_q <= 1'b0;
      end
      if (acq_active && busy_q && conv_rsp.done) begin
        sum_q      <= sum_d;
        conv_cnt_q <= sum_last ? 7'h00 : conv_cnt_q + 7'h01;
      end
      case (state_q)
        ST_WARMUP: begin
          if (cal_done) begin
            state_q <= ST_ZERO;
          end
        end
        ST_ZERO: begin
          if (sum_last) begin
            offset_q <= sum_d;
            sum_q    <= 15'h0000;
            state_q  <= ST_MEASURE;
          end
        end
        ST_MEASURE: begin
          if (sum_last) begin
            state_q <= ST_UPDATE;
          end
        end
        ST_UPDATE: begin
          tenths_q <= tenths_d;
          sum_q    <= 15'h0000;
          state_q  <= ST_MEASURE;
        end
        default: begin
          state_q <= ST_WARMUP;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // decimal conversion and segment patterns
  // --------------------------------------------------------------------------
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      default: seg7 = `PRD_SEG_BLANK;
    endcase
  endfunction

  wire logic       has_hund = (tenths_q >= `PRD_HUNDRED);
  wire logic [7:0] rem      = has_hund ? (tenths_q - `PRD_HUNDRED) : tenths_q;
  wire logic [7:0] tens     = rem / `PRD_TEN;
  wire logic [7:0] units    = rem % `PRD_TEN;

  // leftmost digit stays blank; a leading zero in the tens place is kept as 0.x
  wire logic [31:0] psi_pat = {8'h00,
                               1'b0, has_hund ? seg7(4'h1) : `PRD_SEG_BLANK,
                               1'b1, seg7(tens[3:0]),
                               1'b0, seg7(units[3:0])};
  wire logic [31:0] cal_pat = {8'h00, 1'b0, `PRD_SEG_C, 1'b0, `PRD_SEG_A, 1'b0, `PRD_SEG_L};
  wire logic        show_cal = (state_q == ST_WARMUP) || (state_q == ST_ZERO);
  wire logic [31:0] pattern  = show_cal ? cal_pat : psi_pat;

  // --------------------------------------------------------------------------
  // static lcd drive
  // --------------------------------------------------------------------------
  // a lit segment is driven opposite to the backplane; both flip together so no dc remains
  logic bp_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bp_q    <= 1'b0;
      lcd.bp  <= 1'b0;
      lcd.seg <= 32'h0000_0000;
    end else begin
      if (frame_tick) begin
        bp_q <= ~bp_q;
      end
      lcd.bp  <= bp_q;
      lcd.seg <= pattern ^ {32{bp_q}};
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  channel_fixed_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    conv_req.channel == 3'd5) else $error("converter channel is not five");

  sum_count_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sum_last |=> (conv_cnt_q == 7'h00) && $past(conv_cnt_q) == 7'd99) else $error("sample not 100 reads");

  offset_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_q != ST_WARMUP && state_q != ST_ZERO) |=> $stable(offset_q)) else $error("offset changed");

  range_max_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    tenths_q <= 8'd150) else $error("pressure above 15.0 psi");

  lcd_invert_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    frame_tick |-> ##2 (lcd.bp != $past(lcd.bp)) && (lcd.seg[31:24] == {8{lcd.bp}}))
    else $error("backplane did not invert with data");

  cal_message_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_q == ST_WARMUP) [*2] |->
    (lcd.seg ^ {32{lcd.bp}}) == {8'h00, 1'b0, `PRD_SEG_C, 1'b0, `PRD_SEG_A, 1'b0, `PRD_SEG_L})
    else $error("cal message missing during warm-up");

  span_select_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (jmp_q == 2'b01 |-> span == 9'd446) and (jmp_q == 2'b10 |-> span == 9'd432)
    and (jmp_q[0] == jmp_q[1] |-> span == 9'd439)) else $error("wrong span constant");

  blank_digit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    ##1 lcd.seg[31:24] == {8{lcd.bp}}) else $error("leftmost digit not blank");

  frame_period_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(bp_q) |-> $past(frame_cnt_q) == FRAME_CYCLES - 1) else $error("alternation off timer event");

  clamp_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_q == ST_UPDATE && sum_q <= offset_q) |=> tenths_q == 8'h00) else $error("negative reading not floored");

endmodule

// *** core/pressure_defs.svh ***
// constants for the pressure readout and display controller
`ifndef PRESSURE_DEFS_SVH
`define PRESSURE_DEFS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define PRD_CLK_HZ        125_000_000
`define PRD_CAL_TIME_MS   5000
`define PRD_FRAME_TIME_MS 30
`define PRD_CAL_CYCLES    ((`PRD_CLK_HZ / 1000) * `PRD_CAL_TIME_MS)
`define PRD_FRAME_CYCLES  ((`PRD_CLK_HZ / 1000) * `PRD_FRAME_TIME_MS)

// ----------------------------------------------------------------------------
// converter and accumulation
// ----------------------------------------------------------------------------
`define PRD_ADC_CHANNEL   3'd5
`define PRD_SUM_COUNT     7'd100
`define PRD_SUM_LAST      7'd99

// ----------------------------------------------------------------------------
// span scaling: tenths = ((sum - offset) * span) >> shift
// ----------------------------------------------------------------------------
`define PRD_SPAN_NOM      9'd439
`define PRD_SPAN_RAISE    9'd446
`define PRD_SPAN_LOWER    9'd432
`define PRD_SPAN_SHIFT    16
`define PRD_MAX_TENTHS    8'd150
`define PRD_HUNDRED       8'd100
`define PRD_TEN           8'd10

// ----------------------------------------------------------------------------
// segment codes, gfedcba order
// ----------------------------------------------------------------------------
`define PRD_SEG_BLANK     7'h00
`define PRD_SEG_C         7'h39
`define PRD_SEG_A         7'h77
`define PRD_SEG_L         7'h38

`endif

// *** core/pressure_pkg.sv ***
// types shared by the pressure readout and display controller
package pressure_pkg;

  // conversion request toward the converter
  typedef struct packed {
    logic       start;
    logic [2:0] channel;
  } conv_req_s;

  // conversion answer from the converter
  typedef struct packed {
    logic       done;
    logic [7:0] data;
  } conv_rsp_s;

  // static display drive: 4 digits of {dp, gfedcba} plus backplane
  typedef struct packed {
    logic        bp;
    logic [31:0] seg;
  } lcd_drive_s;

  typedef enum logic [3:0] {
    ST_WARMUP  = 4'b0001,
    ST_ZERO    = 4'b0010,
    ST_MEASURE = 4'b0100,
    ST_UPDATE  = 4'b1000
  } ctrl_state_e;

endpackage

// *** tb/conv_model.sv ***
// converter and sensor model answering each start with a delayed done
`timescale 1ns/1ps

module conv_model
  import pressure_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  conv_req_s       conv_req,
  input  wire logic [7:0] level,
  input  wire logic [1:0] delay,
  output conv_rsp_s       conv_rsp
);
  logic       busy_q;
  logic [1:0] wait_q;

  // one conversion at a time; data toggles while not valid so a stale byte never passes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q   <= 1'b0;
      wait_q   <= 2'd0;
      conv_rsp <= '0;
    end else begin
      conv_rsp.done <= 1'b0;
      conv_rsp.data <= ~conv_rsp.data;
      if (busy_q) begin
        if (wait_q == 2'd0) begin
          conv_rsp.done <= 1'b1;
          conv_rsp.data <= level;
          busy_q        <= 1'b0;
        end else begin
          wait_q <= wait_q - 2'd1;  // slow answer
        end
      end else if (conv_req.start) begin
        busy_q <= 1'b1;
        wait_q <= delay;
      end
    end
  end
endmodule

// *** tb/pressure_readout_display_ctrl_tb_top.sv ***
// self-checking bench for the pressure readout controller
`timescale 1ns/1ps
`include "pressure_defs.svh"

module pressure_readout_display_ctrl_tb_top;
  import pressure_pkg::*;
  localparam int CAL = 200;
  localparam int FRM = 16;
  logic       core_clk          = 1'b0;
  logic       arst_n            = 1'b0;
  logic       span_raise_jumper = 1'b0;
  logic       span_lower_jumper = 1'b0;
  logic [7:0] level             = 8'h0b;
  logic [1:0] delay             = 2'd0;
  conv_req_s  conv_req;
  conv_rsp_s  conv_rsp;
  lcd_drive_s lcd;
  int         failures  = 0;
  int         cmp_count = 0;
  int         seed      = 85;
  int         cyc       = 0;
  int         dones     = 0;
  int         zero      = 11;
  int         corner [5] = '{11, 5, 160, 161, 255};
  logic [6:0] dig [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};

  // --------------------------------------------------------------------------
  // design, converter model and clock
  // --------------------------------------------------------------------------
  pressure_readout_display_ctrl #(.CAL_CYCLES(CAL), .FRAME_CYCLES(FRM)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .span_raise_jumper(span_raise_jumper),
    .span_lower_jumper(span_lower_jumper), .conv_req(conv_req), .conv_rsp(conv_rsp), .lcd(lcd));
  conv_model model (.core_clk(core_clk), .arst_n(arst_n), .conv_req(conv_req), .level(level),
    .delay(delay), .conv_rsp(conv_rsp));
  always #4 core_clk = ~core_clk;

  // --------------------------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // expected un-inverted pattern: hundreds blank below ten psi, tens carries the point
  function automatic logic [31:0] exp_seg(input int lvl, input logic r, input logic l);
    int sp;
    int t;
    sp = (r == l) ? `PRD_SPAN_NOM : (r ? `PRD_SPAN_RAISE : `PRD_SPAN_LOWER);
    t = (lvl > zero) ? ((100 * (lvl - zero) * sp) >>> `PRD_SPAN_SHIFT) : 0;
    if (t > 150) t = 150;
    return {8'h00, (t > 99) ? {1'b0, dig[1]} : 8'h00, 1'b1, dig[(t / 10) % 10], 1'b0, dig[t % 10]};
  endfunction

  // conversion count, channel watch and hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (conv_rsp.done === 1'b1) dones++;
    if (arst_n && conv_req.start === 1'b1) check(conv_req.channel, 3'd5);
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end

  // waits for n conversions plus the update latency, then parks on a falling edge
  task automatic settle(input int n);
    int d0;
    d0 = dones;
    while (dones < d0 + n) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // two full samples at a new level, random converter latency
  task automatic measure(input int lvl);
    @(posedge core_clk);
    level <= lvl[7:0];
    delay <= 2'($random(seed));
    settle(205);
    check(lcd.seg ^ {32{lcd.bp}}, exp_seg(lvl, span_raise_jumper, span_lower_jumper));
  endtask

  task automatic pwr_up(input int z);
    int n;
    @(posedge core_clk);
    arst_n <= 1'b0;
    level  <= z[7:0];
    zero = z;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    check({lcd.bp, conv_req}, 5'h05);
    check(lcd.seg, 32'h0000_0000);
    @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (50) @(posedge core_clk);
    @(negedge core_clk);
    check(lcd.seg ^ {32{lcd.bp}}, {8'h00, 1'b0, `PRD_SEG_C, 1'b0, `PRD_SEG_A, 1'b0, `PRD_SEG_L});
    n = 50;
    while (conv_req.start !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
    check(n, CAL);
    settle(105);
    $display("test power-up with zero level %0d done", z);
  endtask

  // backplane must hold for exactly one frame between alternations
  task automatic frame_check;
    logic b;
    int   n;
    @(negedge core_clk);
    b = lcd.bp;
    while (lcd.bp === b) @(negedge core_clk);
    b = lcd.bp;
    n = 0;
    while (lcd.bp === b) begin
      @(negedge core_clk);
      n++;
    end
    check(n, FRM);
    $display("test frame period done");
  endtask

  // --------------------------------------------------------------------------
  // main sequence: corners and random levels under every jumper setting
  // --------------------------------------------------------------------------
  initial begin
    pwr_up(11);
    frame_check();
    for (int j = 0; j < 4; j++) begin
      @(posedge core_clk);
      {span_raise_jumper, span_lower_jumper} <= j[1:0];
      foreach (corner[i]) measure(corner[i]);
      measure(zero + {$random(seed)} % (256 - zero));
      $display("test jumper setting %0d done", j);
    end
    pwr_up(30);
    measure(30);
    measure(zero + {$random(seed)} % (256 - zero));
    $display("test second power-up done");
    summarize();
  end
endmodule
